// File: bench/pcfr_core_asserts.sv
// Checker for the power-up configuration core
`timescale 1ns/10ps
module pcfr_core_asserts
    import pcfr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Events
    input wire logic io_overvoltage_reset_enable_in,
    input wire logic watchdog_fail_in,
    input wire logic io_overvoltage_event_in,
    // Outputs
    input wire pcfr_wake_level_status_type wake_level_status_reg_out,
    input wire logic [2:0] cfg_code_out,
    input wire logic cfg_valid_out,
    input wire pcfr_mode_type mode_out,
    input wire logic main_regulator_on_out,
    input wire logic fail_output_out,
    input wire logic device_reset_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    wire logic tk = cfg_valid_out && mode_out == PCFR_MODE_NORMAL;
    wire logic ov = tk && io_overvoltage_event_in
        && io_overvoltage_reset_enable_in;
    wire logic wd = tk && watchdog_fail_in && !ov;
    wd_restart_a: assert property (wd &&
        cfg_code_out == PCFR_CFG_1 |=>
        mode_out == PCFR_MODE_RESTART && main_regulator_on_out)
        else $error("watchdog restart wrong");
    wd_failsafe_a: assert property (wd &&
        cfg_code_out == PCFR_CFG_2 |=>
        mode_out == PCFR_MODE_FAILSAFE && !main_regulator_on_out)
        else $error("watchdog fail-safe wrong");
    dev_quiet_a: assert property (tk &&
        cfg_code_out == PCFR_CFG_DEV |=>
        !device_reset_out && mode_out == PCFR_MODE_NORMAL)
        else $error("dev mode reacted");
    ov_restart_a: assert property (ov &&
        cfg_code_out inside {1, 3} |=>
        mode_out == PCFR_MODE_RESTART && fail_output_out)
        else $error("overvoltage restart wrong");
    ov_failsafe_a: assert property (ov &&
        cfg_code_out inside {2, 4} |=>
        mode_out == PCFR_MODE_FAILSAFE && fail_output_out)
        else $error("overvoltage fail-safe wrong");
    cfg_held_a: assert property (cfg_valid_out |=>
        $stable(cfg_code_out) && $stable(wake_level_status_reg_out))
        else $error("config changed");
    status_code_a: assert property (cfg_valid_out &&
        cfg_code_out != 0 |->
        wake_level_status_reg_out == {cfg_code_out inside {1, 2},
        cfg_code_out inside {1, 3}}) else $error("status mismatch");
    entry_pulse_a: assert property ($changed(mode_out) &&
        mode_out != 0 |->
        device_reset_out ##1 !device_reset_out) else $error("reset pulse");
endmodule

bind pcfr_core pcfr_core_asserts u_chk (.core_clk_in, .srst_in,
    .io_overvoltage_reset_enable_in, .watchdog_fail_in,
    .io_overvoltage_event_in, .wake_level_status_reg_out, .cfg_code_out,
    .cfg_valid_out, .mode_out, .main_regulator_on_out, .fail_output_out,
    .device_reset_out);

// File: bench/pcfr_core_tb_top.sv
// Testbench for the power-up configuration core
`timescale 1ns/10ps
module pcfr_core_tb_top
    import pcfr_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic main_is_5v_in = 1'b1;
    logic supply_strap_pin_in = 1'b1;
    logic interrupt_pin_level_in = 1'b0;
    logic failure_count_select_in = 1'b0;
    logic dev_mode_in = 1'b0;
    logic io_overvoltage_reset_enable_in = 1'b0;
    logic io_overvoltage_event_in = 1'b0;
    logic [3:0] latency = 4'h0;
    logic restart_done_in, watchdog_fail_in, cfg_valid_out, supervise_ext_out;
    logic io_level_5v_out, ext_fixed_3v3_out, uv_rerouted_out;
    logic interrupt_out_drive_out, main_regulator_on_out, fail_output_out;
    logic device_reset_out;
    logic [2:0] cfg_code_out;
    pcfr_wake_level_status_type wake_level_status_reg_out;
    pcfr_mode_type mode_out;
    int mismatches = 0;
    int checks = 0;
    always #2.5 core_clk_in = ~core_clk_in;
    pcfr_core DUT (.core_clk_in, .srst_in, .main_is_5v_in,
        .supply_strap_pin_in, .interrupt_pin_level_in,
        .failure_count_select_in, .dev_mode_in,
        .io_overvoltage_reset_enable_in, .restart_done_in, .watchdog_fail_in,
        .io_overvoltage_event_in, .wake_level_status_reg_out, .cfg_code_out,
        .cfg_valid_out, .supervise_ext_out, .io_level_5v_out,
        .ext_fixed_3v3_out, .uv_rerouted_out, .interrupt_out_drive_out,
        .mode_out, .main_regulator_on_out, .fail_output_out,
        .device_reset_out);
    pcfr_mcu_model mcu (.core_clk_in, .mode_in(mode_out),
        .latency_in(latency), .watchdog_fail_out(watchdog_fail_in),
        .restart_done_out(restart_done_in));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic power_up(input logic dev, input logic pin,
            input logic fcs, input logic strap, input logic [2:0] code);
        srst_in = 1'b1;
        {dev_mode_in, interrupt_pin_level_in} = {dev, pin};
        {failure_count_select_in, supply_strap_pin_in} = {fcs, strap};
        io_overvoltage_reset_enable_in = 1'b0;
        repeat (6) @(negedge core_clk_in);
        srst_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        {interrupt_pin_level_in, failure_count_select_in} = {~pin, ~fcs};
        supply_strap_pin_in = ~strap;
        @(negedge core_clk_in);
        chk({cfg_valid_out, interrupt_out_drive_out, cfg_code_out},
            {2'b11, code});
        if (!dev) chk(wake_level_status_reg_out, {fcs, pin});
    endtask
    task automatic fail_ev(input logic wd, input logic [3:0] exp);
        int i;
        if (wd) mcu.miss();
        @(negedge core_clk_in);
        io_overvoltage_event_in = ~wd;
        @(negedge core_clk_in);
        io_overvoltage_event_in = 1'b0;
        chk({mode_out, fail_output_out, device_reset_out}, exp);
        for (i = 0; i < 40 && mode_out === PCFR_MODE_RESTART; i++)
            @(negedge core_clk_in);
        if (i == 40) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic t_cfg1();
        power_up(1'b0, 1'b1, 1'b1, 1'b1, PCFR_CFG_1);
        fail_ev(1'b1, 4'b0111);
        chk(main_regulator_on_out, 1'b1);
        chk({io_level_5v_out, ext_fixed_3v3_out, supervise_ext_out,
            uv_rerouted_out}, 4'b1000);
        $display("cfg1 done");
    endtask
    task automatic t_cfg3();
        power_up(1'b0, 1'b1, 1'b0, 1'b1, PCFR_CFG_3);
        latency = 4'h9;
        fail_ev(1'b1, 4'b0101);
        fail_ev(1'b1, 4'b0111);
        power_up(1'b0, 1'b1, 1'b0, 1'b1, PCFR_CFG_3);
        io_overvoltage_reset_enable_in = 1'b1;
        fail_ev(1'b0, 4'b0111);
        $display("cfg3 done");
    endtask
    task automatic t_cfg4();
        power_up(1'b0, 1'b0, 1'b0, 1'b0, PCFR_CFG_4);
        latency = 4'h0;
        fail_ev(1'b1, 4'b0101);
        fail_ev(1'b1, 4'b1111);
        chk(main_regulator_on_out, 1'b0);
        fail_ev(1'b1, 4'b1110);
        chk({io_level_5v_out, ext_fixed_3v3_out, supervise_ext_out,
            uv_rerouted_out}, 4'b0111);
        $display("cfg4 done");
    endtask
    task automatic t_failure_count_select();
        power_up(1'b0, 1'b0, 1'b1, 1'b1, PCFR_CFG_2);
        fail_ev(1'b0, 4'b0000);
        io_overvoltage_reset_enable_in = 1'b1;
        fail_ev(1'b0, 4'b1111);
        power_up(1'b0, 1'b0, 1'b1, 1'b1, PCFR_CFG_2);
        fail_ev(1'b1, 4'b1111);
        chk(main_regulator_on_out, 1'b0);
        $display("failure_count_select done");
    endtask
    task automatic t_dev();
        power_up(1'b1, 1'b1, 1'b1, 1'b1, PCFR_CFG_DEV);
        fail_ev(1'b1, 4'b0000);
        $display("dev done");
    endtask
    initial begin
        t_cfg1();
        t_cfg3();
        t_cfg4();
        t_failure_count_select();
        t_dev();
        summarize();
    end
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
endmodule

// File: bench/pcfr_mcu_model.sv
// Model of the supervised microcontroller
`timescale 1ns/10ps
module pcfr_mcu_model
    import pcfr_pkg::*;
(
    // Clock and device state
    input wire logic core_clk_in,
    input wire pcfr_mode_type mode_in,
    input wire logic [3:0] latency_in,
    // Toward the device
    output logic watchdog_fail_out,
    output logic restart_done_out
);
    logic miss_req = 1'b0;
    logic pend = 1'b0;
    logic [3:0] cnt = 4'h0;
    initial {watchdog_fail_out, restart_done_out} = 2'h0;
    task automatic miss();
        miss_req = 1'b1;
    endtask
    always @(posedge core_clk_in) begin
        pend <= miss_req;
        miss_req <= 1'b0;
    end
    always @(negedge core_clk_in) begin
        watchdog_fail_out <= pend;
        restart_done_out <= 1'b0;
        if (mode_in != PCFR_MODE_RESTART) cnt <= 4'h0;
        else if (cnt == latency_in) restart_done_out <= 1'b1;
        else cnt <= cnt + 4'h1;
    end
endmodule

// File: rtl/pcfr_core.sv
// Power-up configuration capture and failure response sequencer
`timescale 1ns/10ps
module pcfr_core
    import pcfr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Straps and pins
    input wire logic main_is_5v_in,
    input wire logic supply_strap_pin_in,
    input wire logic interrupt_pin_level_in,
    // Control bits
    input wire logic failure_count_select_in,
    input wire logic dev_mode_in,
    input wire logic io_overvoltage_reset_enable_in,
    input wire logic restart_done_in,
    // Events
    input wire logic watchdog_fail_in,
    input wire logic io_overvoltage_event_in,
    // Configuration status
    output pcfr_wake_level_status_type wake_level_status_reg_out,
    output logic [2:0] cfg_code_out,
    output logic cfg_valid_out,
    output logic supervise_ext_out,
    output logic io_level_5v_out,
    output logic ext_fixed_3v3_out,
    output logic uv_rerouted_out,
    // Sequencer outputs
    output logic interrupt_out_drive_out,
    output pcfr_mode_type mode_out,
    output logic main_regulator_on_out,
    output logic fail_output_out,
    output logic device_reset_out
);

    pcfr_cfg_type cfg;
    logic [PCFR_FAILCNT_W-1:0] fail_count;
    logic [PCFR_FAILCNT_W-1:0] next_count;
    logic restart_family;

    function automatic logic [PCFR_FAILCNT_W-1:0] sat_inc(
        input logic [PCFR_FAILCNT_W-1:0] value
    );
        sat_inc = (value >= PCFR_FAILCNT_MAX) ? PCFR_FAILCNT_MAX
                                              : value + 1'b1;
    endfunction

    pcfr_strap_capture capture_inst (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .main_is_5v_in(main_is_5v_in),
        .supply_strap_pin_in(supply_strap_pin_in),
        .interrupt_pin_level_in(interrupt_pin_level_in),
        .failure_count_select_in(failure_count_select_in),
        .dev_mode_in(dev_mode_in),
        .cfg_out(cfg),
        .cfg_code_out(cfg_code_out)
    );

    assign restart_family = cfg.response_family_state;
    assign next_count = sat_inc(fail_count);

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            wake_level_status_reg_out <= '0;
        end else begin
            wake_level_status_reg_out.failure_count_state <=
                cfg.failure_count_state;
            wake_level_status_reg_out.response_family_state <=
                cfg.response_family_state;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cfg_valid_out <= 1'b0;
            supervise_ext_out <= 1'b0;
            io_level_5v_out <= 1'b0;
            ext_fixed_3v3_out <= 1'b0;
            uv_rerouted_out <= 1'b0;
        end else begin
            cfg_valid_out <= cfg.valid;
            supervise_ext_out <= cfg.supervise_ext;
            io_level_5v_out <= cfg.io_level_5v;
            ext_fixed_3v3_out <= cfg.ext_fixed_3v3;
            uv_rerouted_out <= cfg.uv_rerouted;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            interrupt_out_drive_out <= 1'b0;
        end else begin
            interrupt_out_drive_out <= cfg.valid;
        end
    end

    // Watchdog failure counter
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            fail_count <= PCFR_FAILCNT_RESET;
        end else if (cfg.valid && watchdog_fail_in &&
                     cfg_code_out != PCFR_CFG_DEV) begin
            fail_count <= next_count;
        end
    end

    // Mode sequencer
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            mode_out <= PCFR_MODE_NORMAL;
            main_regulator_on_out <= 1'b1;
            device_reset_out <= 1'b0;
        end else begin
            device_reset_out <= 1'b0;
            unique case (mode_out)
                PCFR_MODE_NORMAL: begin
                    if (!cfg.valid) begin
                        mode_out <= PCFR_MODE_NORMAL;
                    end else if (io_overvoltage_event_in &&
                                 io_overvoltage_reset_enable_in &&
                                 cfg_code_out != PCFR_CFG_DEV) begin
                        device_reset_out <= 1'b1;
                        if (restart_family) begin
                            mode_out <= PCFR_MODE_RESTART;
                        end else begin
                            mode_out <= PCFR_MODE_FAILSAFE;
                            main_regulator_on_out <= 1'b0;
                        end
                    end else if (watchdog_fail_in &&
                                 cfg_code_out != PCFR_CFG_DEV) begin
                        device_reset_out <= 1'b1;
                        if (restart_family) begin
                            mode_out <= PCFR_MODE_RESTART;
                        end else if (cfg_code_out == PCFR_CFG_4 &&
                                     fail_count == PCFR_FAILCNT_RESET) begin
                            mode_out <= PCFR_MODE_RESTART;
                        end else begin
                            mode_out <= PCFR_MODE_FAILSAFE;
                            main_regulator_on_out <= 1'b0;
                        end
                    end
                end
                PCFR_MODE_RESTART: begin
                    if (restart_done_in) begin
                        mode_out <= PCFR_MODE_NORMAL;
                    end
                end
                PCFR_MODE_FAILSAFE: begin
                    main_regulator_on_out <= 1'b0;
                end
                default: begin
                    mode_out <= PCFR_MODE_NORMAL;
                end
            endcase
        end
    end

    // Fail output after first or second failure
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            fail_output_out <= 1'b0;
        end else if (mode_out == PCFR_MODE_NORMAL && cfg.valid &&
                     cfg_code_out != PCFR_CFG_DEV) begin
            if (watchdog_fail_in &&
                (cfg.failure_count_state ||
                 fail_count != PCFR_FAILCNT_RESET)) begin
                fail_output_out <= 1'b1;
            end else if (io_overvoltage_event_in &&
                         io_overvoltage_reset_enable_in) begin
                fail_output_out <= 1'b1;
            end
        end
    end

endmodule

// File: rtl/pcfr_pkg.sv
// Package of types and constants for the power-up configuration block
package pcfr_pkg;

    // Configuration codes
    localparam logic [2:0] PCFR_CFG_DEV = 3'h0;
    localparam logic [2:0] PCFR_CFG_1 = 3'h1;
    localparam logic [2:0] PCFR_CFG_2 = 3'h2;
    localparam logic [2:0] PCFR_CFG_3 = 3'h3;
    localparam logic [2:0] PCFR_CFG_4 = 3'h4;

    // Main output voltage option and strap level encodings
    localparam logic MAIN_IS_5V = 1'h1;
    localparam logic STRAP_GROUNDED = 1'h0;

    // Watchdog failure counter width and saturation
    localparam int PCFR_FAILCNT_W = 2;
    localparam logic [1:0] PCFR_FAILCNT_MAX = 2'h2;

    // Reset values
    localparam logic [2:0] PCFR_CFG_RESET = 3'h0;
    localparam logic [1:0] PCFR_FAILCNT_RESET = 2'h0;

    // Device operating modes along the failure path
    typedef enum logic [1:0] {
        PCFR_MODE_NORMAL = 2'b00,
        PCFR_MODE_RESTART = 2'b01,
        PCFR_MODE_FAILSAFE = 2'b11
    } pcfr_mode_type;

    // Latched hardware configuration
    typedef struct packed {
        logic valid;
        logic io_level_5v;
        logic ext_fixed_3v3;
        logic uv_rerouted;
        logic supervise_ext;
        logic response_family_state;
        logic failure_count_state;
    } pcfr_cfg_type;

    // Wake level status read-back
    typedef struct packed {
        logic failure_count_state;
        logic response_family_state;
    } pcfr_wake_level_status_type;

endpackage

// File: rtl/pcfr_strap_capture.sv
// Captures supply and response straps once at power-on reset release
`timescale 1ns/10ps
module pcfr_strap_capture
    import pcfr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Straps and control
    input wire logic main_is_5v_in,
    input wire logic supply_strap_pin_in,
    input wire logic interrupt_pin_level_in,
    input wire logic failure_count_select_in,
    input wire logic dev_mode_in,
    // Latched configuration
    output pcfr_cfg_type cfg_out,
    output logic [2:0] cfg_code_out
);

    logic captured;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            captured <= 1'b0;
        end else begin
            captured <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cfg_out <= '0;
            cfg_code_out <= PCFR_CFG_RESET;
        end else if (!captured) begin
            cfg_out.valid <= 1'b1;
            // Open strap, I/O at main level
            cfg_out.io_level_5v <= main_is_5v_in &&
                supply_strap_pin_in != STRAP_GROUNDED;
            cfg_out.ext_fixed_3v3 <= main_is_5v_in == MAIN_IS_5V &&
                supply_strap_pin_in == STRAP_GROUNDED;
            cfg_out.uv_rerouted <= main_is_5v_in == MAIN_IS_5V &&
                supply_strap_pin_in == STRAP_GROUNDED;
            cfg_out.supervise_ext <= main_is_5v_in == MAIN_IS_5V &&
                supply_strap_pin_in == STRAP_GROUNDED;
            cfg_out.response_family_state <= interrupt_pin_level_in;
            cfg_out.failure_count_state <= failure_count_select_in;
            if (dev_mode_in) begin
                cfg_code_out <= PCFR_CFG_DEV;
            end else if (failure_count_select_in) begin
                cfg_code_out <= interrupt_pin_level_in ? PCFR_CFG_1
                                                       : PCFR_CFG_2;
            end else begin
                cfg_code_out <= interrupt_pin_level_in ? PCFR_CFG_3
                                                       : PCFR_CFG_4;
            end
        end
    end

endmodule
